// *** hw/afe_link_pkg.sv ***
// Purpose: Shared constants, types and helpers for both ends of the front-end link
// Assumes: One system clock ref_clk; the link clock travels as an ordinary pin
// Notes: Control frame is a read flag, four address bits, eight data bits, MSB first
package afe_link_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int TX_W = 4;
  localparam int RX_W = 6;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NREG = 16;

  // ----------------------------------------------------------------
  // Control frame layout
  // ----------------------------------------------------------------
  localparam int HDR_BITS = 1 + ADDR_W;
  localparam int FRAME_BITS = HDR_BITS + DATA_W;
  localparam logic [3:0] HDR_LAST = 4'h4;
  localparam logic [3:0] DATA_LAST = 4'hc;
  localparam logic [3:0] FRAME_END = 4'hd;
  localparam logic [3:0] RD_FIRST = 4'h6;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic RW_READ = 1'b1;

  // ----------------------------------------------------------------
  // Reset and idle values
  // ----------------------------------------------------------------
  localparam logic OUT_IDLE = 1'b0;
  localparam logic SELECT_IDLE = 1'b1;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_PEND = 2'b01,
    H_SHIFT = 2'b10
  } host_state_e;

  // A change of a synchronised pin counts once two stages agree
  function automatic logic agree(input logic s2, input logic s3, input logic old);
    agree = (s2 == s3) ? s2 : old;
  endfunction

endpackage

// *** hw/afe_link_if.sv ***
// Purpose: Pin bundle between the front end and the transceiver logic
// Assumes: All pins are one-way; no enables needed
// Notes: The link clock is a plain signal here, the front end drives it and the transceiver samples it
`timescale 1ns/1ns
interface afe_link_if;
  logic [afe_link_pkg::TX_W-1:0] tx_symbol;
  logic [afe_link_pkg::RX_W-1:0] rx_sample;
  logic half_crystal_timing_clock;
  logic ctrl_serial_in;
  logic ctrl_serial_out;
  logic ctrl_link_select_n;

  modport afe (
    input tx_symbol,
    output rx_sample,
    output half_crystal_timing_clock,
    input ctrl_serial_in,
    output ctrl_serial_out,
    input ctrl_link_select_n
  );

  modport xcvr (
    output tx_symbol,
    input rx_sample,
    input half_crystal_timing_clock,
    output ctrl_serial_in,
    input ctrl_serial_out,
    output ctrl_link_select_n
  );
endinterface

// *** hw/xcvr_end.sv ***
// Purpose: Transceiver side of the link: symbol out, receive word in, control master
// Assumes: Link clock period spans several ref_clk cycles (crystal near 21.5 MHz)
// Notes: Outputs change just after a seen rising edge to give the far end setup
`timescale 1ns/1ns
module xcvr_end (
  input wire logic ref_clk,
  input wire logic rst_n,
  afe_link_if.xcvr link,
  input wire logic [afe_link_pkg::TX_W-1:0] tx_symbol_in,
  output logic tx_symbol_taken,
  output logic [afe_link_pkg::RX_W-1:0] rx_sample_out,
  output logic rx_sample_strobe,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [afe_link_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [afe_link_pkg::DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [afe_link_pkg::DATA_W-1:0] rsp_rdata
);

  localparam int IN_W = afe_link_pkg::RX_W + 2;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [IN_W-1:0] s1_q, s2_q, s3_q, filt_q;
  logic [IN_W-1:0] filt_d;
  logic clk_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_filt
      assign filt_d[gi] = afe_link_pkg::agree(s2_q[gi], s3_q[gi], filt_q[gi]);
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      s1_q <= {link.half_crystal_timing_clock, link.ctrl_serial_out, link.rx_sample};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      clk_prev_q <= filt_q[IN_W-1];
    end
  end

  wire lclk = filt_q[IN_W-1];
  wire sout = filt_q[IN_W-2];
  wire [afe_link_pkg::RX_W-1:0] rx_pin = filt_q[afe_link_pkg::RX_W-1:0];
  wire l_rise = lclk & ~clk_prev_q;
  wire l_fall = ~lclk & clk_prev_q;

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  logic [afe_link_pkg::TX_W-1:0] tx_q;
  logic tx_taken_q, rx_stb_q;
  logic [afe_link_pkg::RX_W-1:0] rx_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_q <= '0;
      tx_taken_q <= 1'b0;
      rx_q <= '0;
      rx_stb_q <= 1'b0;
    end else begin
      tx_taken_q <= l_rise;
      rx_stb_q <= l_fall;
      if (l_rise) tx_q <= tx_symbol_in;
      if (l_fall) rx_q <= rx_pin;
    end
  end

  // ----------------------------------------------------------------
  // Control master
  // ----------------------------------------------------------------
  afe_link_pkg::host_state_e st_q;
  logic [afe_link_pkg::FRAME_BITS-1:0] fr_q;
  logic [3:0] cnt_q;
  logic rd_q, sel_n_q, sin_q, ready_q, rsp_q;
  logic [afe_link_pkg::DATA_W-1:0] rd_sh_q;

  wire take = (st_q == afe_link_pkg::H_IDLE) & cmd_valid & ready_q;
  wire at_end = (cnt_q == afe_link_pkg::FRAME_END);
  wire rd_slot = rd_q & (cnt_q >= afe_link_pkg::RD_FIRST);
  wire [afe_link_pkg::DATA_W-1:0] wdata = cmd_write ? cmd_wdata : afe_link_pkg::REG_RESET;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= afe_link_pkg::H_IDLE;
      fr_q <= '0;
      cnt_q <= afe_link_pkg::CNT_ZERO;
      rd_q <= 1'b0;
      sel_n_q <= afe_link_pkg::SELECT_IDLE;
      sin_q <= 1'b0;
      ready_q <= 1'b0;
      rsp_q <= 1'b0;
      rd_sh_q <= afe_link_pkg::REG_RESET;
    end else begin
      rsp_q <= 1'b0;
      unique case (st_q)
        afe_link_pkg::H_IDLE: begin
          ready_q <= 1'b1;
          if (take) begin
            fr_q <= {~cmd_write, cmd_addr, wdata};
            rd_q <= ~cmd_write;
            ready_q <= 1'b0;
            st_q <= afe_link_pkg::H_PEND;
          end
        end
        afe_link_pkg::H_PEND: begin
          if (l_rise) begin
            sel_n_q <= 1'b0;
            sin_q <= fr_q[afe_link_pkg::FRAME_BITS-1];
            fr_q <= fr_q << 1;
            cnt_q <= afe_link_pkg::CNT_ONE;
            st_q <= afe_link_pkg::H_SHIFT;
          end
        end
        afe_link_pkg::H_SHIFT: begin
          if (l_rise && at_end) begin
            sel_n_q <= afe_link_pkg::SELECT_IDLE;
            sin_q <= 1'b0;
            cnt_q <= afe_link_pkg::CNT_ZERO;
            rsp_q <= 1'b1;
            st_q <= afe_link_pkg::H_IDLE;
          end else if (l_rise) begin
            sin_q <= fr_q[afe_link_pkg::FRAME_BITS-1];
            fr_q <= fr_q << 1;
            cnt_q <= cnt_q + afe_link_pkg::CNT_ONE;
          end
          if (l_fall && rd_slot) rd_sh_q <= {rd_sh_q[afe_link_pkg::DATA_W-2:0], sout};
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.tx_symbol = tx_q;
  assign link.ctrl_serial_in = sin_q;
  assign link.ctrl_link_select_n = sel_n_q;
  assign tx_symbol_taken = tx_taken_q;
  assign rx_sample_out = rx_q;
  assign rx_sample_strobe = rx_stb_q;
  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rd_sh_q;

endmodule

// *** hw/afe_end.sv ***
// Purpose: Front-end side of the link: divided clock, symbol capture, word launch,
//   serial control register slave
// Assumes: crystal_in is a free-running oscillator well below half of ref_clk
// Notes: Host pins are resynchronised, so the host must change them just after
//   a rising link edge; a frame needs thirteen rising edges with select low
`timescale 1ns/1ns
module afe_end (
  input wire logic ref_clk,
  input wire logic rst_n,
  afe_link_if.afe link,
  input wire logic crystal_in,
  output logic crystal_out,
  input wire logic [afe_link_pkg::RX_W-1:0] rx_sample_in,
  output logic [afe_link_pkg::TX_W-1:0] tx_symbol_out,
  output logic tx_symbol_strobe,
  output logic [afe_link_pkg::NREG*afe_link_pkg::DATA_W-1:0] setup_regs
);

  localparam int IN_W = afe_link_pkg::TX_W + 2;
  localparam int DW = afe_link_pkg::DATA_W;
  localparam int AW = afe_link_pkg::ADDR_W;
  // Host pins rest at their idle levels, so a false select cannot follow reset
  localparam logic [IN_W-1:0] PIN_IDLE = {afe_link_pkg::SELECT_IDLE, {(IN_W-1){1'b0}}};
  // Starting the crystal chain high means the first rise seen after reset is a
  // real crystal edge, so the first link clock phase has its full length
  localparam logic XTAL_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Crystal synchroniser
  // ----------------------------------------------------------------
  logic xs1_q, xs2_q, xs3_q, xf_q, xf_prev_q;
  logic xout_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xs1_q <= XTAL_RESET;
      xs2_q <= XTAL_RESET;
      xs3_q <= XTAL_RESET;
      xf_q <= XTAL_RESET;
      xf_prev_q <= XTAL_RESET;
      xout_q <= 1'b1;
    end else begin
      xs1_q <= crystal_in;
      xs2_q <= xs1_q;
      xs3_q <= xs2_q;
      xf_q <= afe_link_pkg::agree(xs2_q, xs3_q, xf_q);
      xf_prev_q <= xf_q;
      xout_q <= ~xf_q;
    end
  end

  wire x_rise = xf_q & ~xf_prev_q;

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  // Toggling on each crystal rise halves the rate; the link clock is a
  // register, so its edges are exact ref_clk edges seen by all logic here
  logic lclk_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lclk_q <= 1'b0;
    end else if (x_rise) begin
      lclk_q <= ~lclk_q;
    end
  end

  wire l_rise = x_rise & ~lclk_q;

  // ----------------------------------------------------------------
  // Host pin synchronisers
  // ----------------------------------------------------------------
  logic [IN_W-1:0] s1_q, s2_q, s3_q, filt_q;
  logic [IN_W-1:0] filt_d;

  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_filt
      assign filt_d[gi] = afe_link_pkg::agree(s2_q[gi], s3_q[gi], filt_q[gi]);
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
      filt_q <= PIN_IDLE;
    end else begin
      s1_q <= {link.ctrl_link_select_n, link.ctrl_serial_in, link.tx_symbol};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  wire sel_n = filt_q[IN_W-1];
  wire sin = filt_q[IN_W-2];
  wire [afe_link_pkg::TX_W-1:0] tx_pin = filt_q[afe_link_pkg::TX_W-1:0];

  // ----------------------------------------------------------------
  // Transmit capture and receive launch
  // ----------------------------------------------------------------
  logic [afe_link_pkg::TX_W-1:0] tx_q;
  logic tx_stb_q;
  logic [afe_link_pkg::RX_W-1:0] rx_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_q <= '0;
      tx_stb_q <= 1'b0;
      rx_q <= '0;
    end else begin
      tx_stb_q <= l_rise;
      if (l_rise) begin
        tx_q <= tx_pin;
        rx_q <= rx_sample_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control frame decode
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;
  logic [afe_link_pkg::FRAME_BITS-2:0] sh_q;
  logic [AW-1:0] addr_q;
  logic rw_q;
  logic [DW-1:0] out_sh_q;
  logic out_q;
  logic [DW-1:0] regs_q [afe_link_pkg::NREG];

  // Sampling only while selected keeps a stray toggle from shifting a frame
  wire active = l_rise & ~sel_n;
  wire at_hdr = (cnt_q == afe_link_pkg::HDR_LAST);
  wire at_data = (cnt_q == afe_link_pkg::DATA_LAST);
  wire in_read = (cnt_q > afe_link_pkg::HDR_LAST) & (cnt_q < afe_link_pkg::DATA_LAST);
  wire hdr_rw = sh_q[afe_link_pkg::HDR_BITS-2];
  wire [AW-1:0] hdr_addr = {sh_q[AW-2:0], sin};
  wire [DW-1:0] hdr_rdata = regs_q[hdr_addr];
  wire [DW-1:0] wr_data = {sh_q[DW-2:0], sin};
  wire do_write = active & at_data & (rw_q != afe_link_pkg::RW_READ);
  wire do_load = active & at_hdr & (hdr_rw == afe_link_pkg::RW_READ);
  wire do_shift = active & in_read & (rw_q == afe_link_pkg::RW_READ);
  wire cnt_full = (cnt_q == afe_link_pkg::FRAME_END);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= afe_link_pkg::CNT_ZERO;
      sh_q <= '0;
      addr_q <= '0;
      rw_q <= 1'b0;
    end else if (l_rise && sel_n) begin
      cnt_q <= afe_link_pkg::CNT_ZERO;
    end else if (active && !cnt_full) begin
      sh_q <= {sh_q[afe_link_pkg::FRAME_BITS-3:0], sin};
      cnt_q <= cnt_q + afe_link_pkg::CNT_ONE;
      if (at_hdr) begin
        addr_q <= hdr_addr;
        rw_q <= hdr_rw;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data shifter
  // ----------------------------------------------------------------
  // Output is only ever updated on a link rise, so the host may sample it
  // anywhere in the low half of the period
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_sh_q <= afe_link_pkg::REG_RESET;
      out_q <= afe_link_pkg::OUT_IDLE;
    end else if (l_rise && sel_n) begin
      out_q <= afe_link_pkg::OUT_IDLE;
    end else if (do_load) begin
      out_sh_q <= hdr_rdata;
      out_q <= hdr_rdata[DW-1];
    end else if (do_shift) begin
      out_sh_q <= {out_sh_q[DW-2:0], 1'b0};
      out_q <= out_sh_q[DW-2];
    end else if (active) begin
      out_q <= afe_link_pkg::OUT_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Set-up registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < afe_link_pkg::NREG; i++) begin
        regs_q[i] <= afe_link_pkg::REG_RESET;
      end
    end else if (do_write) begin
      regs_q[addr_q] <= wr_data;
    end
  end

  generate
    for (gi = 0; gi < afe_link_pkg::NREG; gi++) begin : g_flat
      assign setup_regs[gi*DW +: DW] = regs_q[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.half_crystal_timing_clock = lclk_q;
  assign link.rx_sample = rx_q;
  assign link.ctrl_serial_out = out_q;
  assign crystal_out = xout_q;
  assign tx_symbol_out = tx_q;
  assign tx_symbol_strobe = tx_stb_q;

endmodule

// *** tb/afe_link_monitor.sv ***
// Purpose: Concurrent checks on the pins that join the two ends
// Assumes: Crystal toggles every four ref_clk cycles, so a link level stands 8 cycles
// Notes: Instantiated beside the interface; no bind
`timescale 1ns/1ns
module afe_link_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [afe_link_pkg::TX_W-1:0] tx_symbol,
  input wire logic [afe_link_pkg::RX_W-1:0] rx_sample,
  input wire logic half_crystal_timing_clock,
  input wire logic ctrl_serial_in,
  input wire logic ctrl_serial_out,
  input wire logic ctrl_link_select_n
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Thirteen link periods of 16 cycles; slack covers the resync delay
  localparam int LOW_MIN = 200;
  localparam int LOW_MAX = 216;
  wire lclk = half_crystal_timing_clock;
  logic [8:0] low_cnt_q;
  logic [8:0] low_cnt_d;
  assign low_cnt_d = ctrl_link_select_n ? 9'h000 : low_cnt_q + 9'h001;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      low_cnt_q <= 9'h000;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence high_phase;
    lclk [*8] ##1 !lclk;
  endsequence
  sequence low_phase;
    !lclk [*8] ##1 lclk;
  endsequence
  clk_high_a: assert property ($rose(lclk) |-> high_phase)
    else $error("link clock high phase wrong");
  clk_low_a: assert property ($fell(lclk) |-> low_phase)
    else $error("link clock low phase wrong");
  rx_launch_a: assert property (!$stable(rx_sample) |-> $rose(lclk))
    else $error("receive word moved off a link rise");
  out_launch_a: assert property (!$stable(ctrl_serial_out) |-> $rose(lclk))
    else $error("serial out moved off a link rise");
  sym_setup_a: assert property (!$stable(tx_symbol) |-> lclk && $past(lclk))
    else $error("symbol moved near a link rise");
  din_setup_a: assert property (!$stable(ctrl_serial_in) |-> lclk && $past(lclk))
    else $error("serial in moved near a link rise");
  sel_setup_a: assert property (!$stable(ctrl_link_select_n) |-> lclk && $past(lclk))
    else $error("select moved near a link rise");
  frame_len_a: assert property ($rose(ctrl_link_select_n) |->
    low_cnt_q >= LOW_MIN && low_cnt_q <= LOW_MAX)
    else $error("select low for wrong length");
  idle_out_a: assert property ($rose(lclk) && ctrl_link_select_n |->
    ctrl_serial_out == afe_link_pkg::OUT_IDLE)
    else $error("serial out not idle while deselected");
  out_select_a: assert property (ctrl_serial_out |-> !ctrl_link_select_n)
    else $error("serial out active without select");
endmodule

// *** tb/testbench.sv ***
// Purpose: Drives both ends through their user ports and checks the results
// Assumes: Crystal toggles every XTAL_HALF ref_clk edges
// Notes: Link period is 4*XTAL_HALF cycles; a control frame takes about 230 cycles
`timescale 1ns/1ns
module testbench;
  localparam int XTAL_HALF = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic crystal_in = 1'b0;
  logic [1:0] xtal_cnt_q = 2'h0;
  logic [5:0] rx_in = 6'h00;
  logic [3:0] sym_in = 4'h0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [3:0] cmd_addr = 4'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic [3:0] sym_out;
  logic sym_strobe;
  logic sym_taken;
  logic [127:0] regs;
  logic [5:0] rx_out;
  logic rx_strobe;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  logic [4:0] pulses;
  logic xtal_out;
  logic [7:0] model [16] = '{default: 8'h00};
  logic [3:0] sym_tab [4] = '{4'ha, 4'h5, 4'hf, 4'h0};
  logic [5:0] rx_tab [4] = '{6'h2a, 6'h15, 6'h3f, 6'h00};
  logic [3:0] wa [4] = '{4'h0, 4'hf, 4'h5, 4'h0};
  logic [7:0] wd [4] = '{8'hff, 8'h81, 8'h3c, 8'ha5};
  int fail_count = 0;
  int checked = 0;
  time t0;
  assign pulses = {sym_taken, cmd_ready, rsp_valid, rx_strobe, sym_strobe};

  afe_link_if link_bus ();
  afe_end u_afe_end (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_bus),
    .crystal_in(crystal_in), .crystal_out(xtal_out), .rx_sample_in(rx_in),
    .tx_symbol_out(sym_out), .tx_symbol_strobe(sym_strobe), .setup_regs(regs));
  xcvr_end u_xcvr_end (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_bus),
    .tx_symbol_in(sym_in), .tx_symbol_taken(sym_taken), .rx_sample_out(rx_out),
    .rx_sample_strobe(rx_strobe), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  afe_link_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n), .tx_symbol(link_bus.tx_symbol),
    .rx_sample(link_bus.rx_sample),
    .half_crystal_timing_clock(link_bus.half_crystal_timing_clock),
    .ctrl_serial_in(link_bus.ctrl_serial_in), .ctrl_serial_out(link_bus.ctrl_serial_out),
    .ctrl_link_select_n(link_bus.ctrl_link_select_n));

  // ----------------------------------------------------------------
  // Clocks
  // ----------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    xtal_cnt_q <= xtal_cnt_q + 2'h1;
    if (xtal_cnt_q == 2'(XTAL_HALF - 1)) begin
      crystal_in <= ~crystal_in;
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic compare(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for one of the user-side flags, seen at a rising edge
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (n < 400 && pulses[which] !== 1'b1);
    if (pulses[which] !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask

  // Offer a command, hold it until taken, then wait for the end of the frame
  task automatic command(input logic wr, input logic [3:0] addr, input logic [7:0] data);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= addr;
    cmd_wdata <= data;
    wait_for(3);
    cmd_valid <= 1'b0;
    wait_for(2);
  endtask

  function automatic logic [127:0] packed_model();
    logic [127:0] f;
    for (int k = 0; k < 16; k++) begin
      f[8*k+:8] = model[k];
    end
    return f;
  endfunction

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    compare(regs, 128'h0);
    compare({link_bus.ctrl_link_select_n, link_bus.ctrl_serial_out}, 2'b10);
    wait_for(0);
    t0 = $time;
    wait_for(0);
    compare($time - t0, 4 * XTAL_HALF * 10);
    compare(xtal_out, 1'b0);
    repeat (4) @(posedge ref_clk);
    compare(xtal_out, 1'b1);
    for (int i = 0; i < 4; i++) begin
      sym_in <= sym_tab[i];
      rx_in <= rx_tab[i];
      repeat (3) wait_for(0);
      compare(sym_out, sym_tab[i]);
      compare(link_bus.rx_sample, rx_tab[i]);
      wait_for(1);
      compare(rx_out, rx_tab[i]);
      wait_for(4);
      compare(link_bus.tx_symbol, sym_tab[i]);
    end
    // Back-to-back writes, address 0 written twice to catch a stale update
    for (int i = 0; i < 4; i++) begin
      command(1'b1, wa[i], wd[i]);
      model[wa[i]] = wd[i];
      compare(regs, packed_model());
    end
    // Reading the whole map also shows idle periods left other registers alone
    for (int k = 0; k < 16; k++) begin
      command(1'b0, 4'(k), 8'h00);
      compare(rsp_rdata, model[k]);
      compare(regs, packed_model());
    end
    stop_test();
  end
endmodule
